// *** bench/axis_bank_checker.sv ***
// Checker of bus answer and commit timing of the parameter bank
`timescale 1ns/1ps
module axis_bank_checker
    import axis_param_pkg::*;
(
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    // Events and status
    input wire logic [1:0] homing_start,
    input wire logic program_start,
    input wire logic [1:0] operation_start,
    input wire logic manual_mode,
    input wire logic [1:0] servo_lock,
    input wire logic [1:0][31:0] accum_error,
    // Results
    input wire logic [1:0][31:0] ref_offset,
    input wire logic [1:0][31:0] work_offset,
    input wire logic [1:0][31:0] feed_limits,
    input wire logic [1:0][31:0] jog_limit,
    input wire logic [1:0][31:0] ramp_times,
    input wire logic [1:0][31:0] interp_ramp_times,
    input wire logic [1:0][31:0] stroke_neg,
    input wire logic [1:0] cmd_reverse,
    input wire logic [1:0] err_alarm,
    input wire logic [1:0] stop_zero,
    input wire logic [1:0] stop_drain,
    input wire logic [1:0] wiring_check_go
);
    logic [8:0] wa_r;
    logic [31:0] warn_r;
    logic alarm_r;
    logic [3:0] quiet_r;

    ////////////////////////////////////////////////////////////////////////
    // Write address, warning level and cycles since restart
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wa_r <= '0;
            warn_r <= '0;
            alarm_r <= 1'b0;
            quiet_r <= '0;
        end
        else
        begin
            wa_r <= {hsel && htrans[1] && hready && hwrite, haddr[7:0]};
            if (wa_r == {1'b1, AXIS0_SEL, IDX_WARN, 2'h0})
                warn_r <= hwdata;
            alarm_r <= accum_error[0] > warn_r;
            if (wa_r == {1'b1, OFS_CTRL} && hwdata[CTRL_RESTART])
                quiet_r <= '0;
            else if (quiet_r != 4'hf)
                quiet_r <= quiet_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_bus_okay;
        hreadyout && hresp == RESP_OKAY;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus answer not ready or not okay");
    property p_ref_hold;
        !homing_start[0] |=> $stable(ref_offset[0]);
    endproperty
    a_ref_hold: assert property (p_ref_hold)
        else $error("reference offset changed without origin search");
    property p_work_hold;
        !program_start |=> $stable(work_offset[0])
            && $stable(interp_ramp_times[0]);
    endproperty
    a_work_hold: assert property (p_work_hold)
        else $error("program start value changed without program start");
    property p_feed_hold;
        !operation_start[0] |=> $stable(feed_limits[0])
            && $stable(jog_limit[0]);
    endproperty
    a_feed_hold: assert property (p_feed_hold)
        else $error("feed limit changed without operation start");
    property p_ramp_hold;
        !(manual_mode ? operation_start[0] : program_start)
            |=> $stable(ramp_times[0]);
    endproperty
    a_ramp_hold: assert property (p_ramp_hold)
        else $error("ramp times changed at the wrong event");
    property p_mech_hold;
        quiet_r >= 4'h4 && wa_r != {1'b1, OFS_CTRL}
            |=> $stable(stroke_neg[0]) && $stable(cmd_reverse[0]);
    endproperty
    a_mech_hold: assert property (p_mech_hold)
        else $error("mechanical value changed without restart");
    property p_alarm;
        err_alarm[0] == alarm_r;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("error alarm does not follow warning level");
    property p_wire_go;
        wiring_check_go[0] |-> $past(servo_lock[0])
            && !$past(servo_lock[0], 2) ##1 !wiring_check_go[0];
    endproperty
    a_wire_go: assert property (p_wire_go)
        else $error("wiring check start not tied to servo lock");
    property p_stop_excl;
        !(stop_zero[0] && stop_drain[0]);
    endproperty
    a_stop_excl: assert property (p_stop_excl)
        else $error("both stop methods active");

    c_homing: cover property (homing_start[0] ##1 $changed(ref_offset[0]));
    c_restart: cover property (quiet_r == 4'h0);
    c_alarm: cover property ($rose(err_alarm[0]));
endmodule

bind axis_parameter_commit_bank axis_bank_checker axis_bank_checker_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .homing_start, .program_start, .operation_start,
    .manual_mode, .servo_lock, .accum_error, .ref_offset, .work_offset,
    .feed_limits, .jog_limit, .ramp_times, .interp_ramp_times, .stroke_neg,
    .cmd_reverse, .err_alarm, .stop_zero, .stop_drain, .wiring_check_go
);

// *** bench/host_tool_model.sv ***
// Host tool model: AHB-Lite master that loads parameter words
`timescale 1ns/1ps
module host_tool_model
    import axis_param_pkg::*;
(
    // Clock
    input wire logic hclk,
    // AHB-Lite master side
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
    end

    // Entered right after a rising edge; returns at one
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ_BIT;
        hwrite <= w;
        do @(posedge hclk); while (!hready);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= w ? d : ~hwdata;
        do @(posedge hclk); while (!hready);
        q = hrdata;
        hwdata <= ~hwdata;
    endtask

    // Emulated power cycle after loading
    task automatic restart();
        logic [31:0] q;
        xfer(1'b1, {24'h0, OFS_CTRL}, 32'h1 << CTRL_RESTART, q);
    endtask
endmodule

// *** bench/tb_axis_parameter_commit_bank.sv ***
// Self-checking bench of the axis parameter commit bank
`timescale 1ns/1ps
module tb_axis_parameter_commit_bank
    import axis_param_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hready, hreadyout, program_start, manual_mode;
    logic [31:0] haddr, hwdata, hrdata, unit_cfg, task1_range, task2_range;
    logic [1:0] htrans, hresp, homing_start, operation_start, homing_active;
    logic [2:0] hsize;
    logic [1:0] servo_lock, abs_init_done, abs_srst_done, prox_pin, stop_pin;
    logic [1:0][31:0] accum_error, abs_value, stroke_neg, stroke_pos;
    logic [1:0][31:0] wiring_cfg, ref_offset, work_offset, feed_limits;
    logic [1:0][31:0] jog_limit, ramp_times, interp_ramp_times;
    logic [1:0][1:0] display_unit, home_method;
    logic [1:0][15:0] home_speed;
    logic [1:0] cmd_reverse, fb_reverse, absolute_encoder_type, home_negative;
    logic [1:0] prox_active, err_alarm, stop_zero, stop_drain, wiring_check_go;
    logic [31:0] exp_q[$], got_q[$], seed, q, v, m, ps;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    int i;

    assign hready = hreadyout;
    always #2 hclk = ~hclk;

    axis_parameter_commit_bank axis_parameter_commit_bank_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hrdata, .hresp, .homing_start, .program_start,
        .operation_start, .manual_mode, .homing_active, .servo_lock,
        .accum_error, .abs_init_done, .abs_srst_done, .abs_value, .prox_pin,
        .stop_pin, .unit_cfg, .task1_range, .task2_range, .display_unit,
        .cmd_reverse, .fb_reverse, .absolute_encoder_type, .home_method,
        .home_negative, .stroke_neg, .stroke_pos, .wiring_cfg, .ref_offset,
        .work_offset, .feed_limits, .jog_limit, .ramp_times,
        .interp_ramp_times, .home_speed, .prox_active, .err_alarm,
        .stop_zero, .stop_drain, .wiring_check_go
    );
    host_tool_model host_tool_model_inst (
        .hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] ax(input logic [3:0] k);
        return {AXIS0_SEL, k, 2'h0};
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        exp_q.push_back(e);
        got_q.push_back(a);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_tool_model_inst.xfer(1'b1, {24'h0, a}, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host_tool_model_inst.xfer(1'b0, {24'h0, a}, 32'h0, q);
        chk(e, q);
    endtask
    // Bit 0 origin search, bit 1 program start, bit 2 operation start
    task automatic fire(input logic [2:0] k);
        homing_start <= {1'b0, k[0]};
        program_start <= k[1];
        operation_start <= {1'b0, k[2]};
        @(posedge hclk);
        homing_start <= 2'h0;
        program_start <= 1'b0;
        operation_start <= 2'h0;
        @(posedge hclk);
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Result monitor and run limit
    always @(negedge hclk)
    begin
        while (got_q.size() > 0)
        begin
            checks++;
            if (got_q[0] !== exp_q[0])
            begin
                bad_count++;
                $display("[FAIL] %0t got %h exp %h", $time, got_q[0], exp_q[0]);
            end
            void'(got_q.pop_front());
            void'(exp_q.pop_front());
        end
    end
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'hb816;
        ps = '0;
        {homing_start, operation_start, homing_active, servo_lock} = '0;
        {abs_init_done, abs_srst_done, prox_pin, stop_pin} = '0;
        {program_start, manual_mode, accum_error, abs_value} = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_STATUS, 32'h1 << ST_BOOT);
        rd(8'h24, RDATA_NONE);
        v = rnd();
        wr(ax(IDX_ABSI), v);
        rd(ax(IDX_ABSI), RDATA_NONE);
        abs_value <= {32'h0, v};
        abs_init_done <= 2'h1;
        @(posedge hclk);
        abs_init_done <= 2'h0;
        @(posedge hclk);
        rd(ax(IDX_ABSI), v);
        // Every display unit and homing methods 0 to 2 through a restart
        for (i = 0; i < 4; i++)
        begin
            m = {21'h0, i[0], i[0], i[1], 2'(i % 3), i[1], i[0], i[0], i[1],
                i[1:0]};
            v = rnd();
            wr(ax(IDX_MECH), m);
            wr(ax(IDX_SNEG), v);
            wr(ax(IDX_SPOS), ~v);
            wr(OFS_UNIT, m);
            rd(ax(IDX_MECH), m);
            chk(ps, stroke_neg[0]);
            host_tool_model_inst.restart();
            repeat (4) @(posedge hclk);
            chk(v, stroke_neg[0]);
            chk(~v, stroke_pos[0]);
            chk(m, unit_cfg);
            chk(m[1:0], display_unit[0]);
            chk({m[8], m[7:6]}, {home_negative[0], home_method[0]});
            chk({m[5:4], m[2]}, {fb_reverse[0], absolute_encoder_type[0],
                cmd_reverse[0]});
            ps = v;
        end
        chk(1, prox_active[0]);
        prox_pin <= 2'h1;
        stop_pin <= 2'h1;
        servo_lock <= 2'h1;
        repeat (4) @(posedge hclk);
        chk(0, prox_active[0]);
        chk(2'h1, {stop_zero[0], stop_drain[0]});
        v = rnd();
        for (i = 4; i < 11; i++)
            wr(ax(i[3:0]), v + i);
        fire(3'h1);
        chk(v + 4, ref_offset[0]);
        chk(0, work_offset[0]);
        fire(3'h2);
        chk(v + 5, work_offset[0]);
        chk(v + 10, interp_ramp_times[0]);
        chk(v + 9, ramp_times[0]);
        chk(0, feed_limits[0]);
        fire(3'h4);
        chk(v + 6, feed_limits[0]);
        chk(v + 8, jog_limit[0]);
        homing_active <= 2'h1;
        repeat (2) @(posedge hclk);
        chk(16'(v + 7), home_speed[0]);
        prox_pin <= 2'h0;
        repeat (4) @(posedge hclk);
        chk((v + 7) >> 16, home_speed[0]);
        manual_mode <= 1'b1;
        wr(ax(IDX_ACC), ~v);
        fire(3'h2);
        chk(v + 9, ramp_times[0]);
        fire(3'h4);
        chk(~v, ramp_times[0]);
        v = rnd();
        wr(OFS_TASK1, v);
        wr(OFS_TASK2, ~v);
        @(posedge hclk);
        chk(v, task1_range);
        chk(~v, task2_range);
        wr(ax(IDX_WARN), 32'h64);
        accum_error <= {32'h0, 32'h65};
        repeat (2) @(posedge hclk);
        chk(1, err_alarm[0]);
        rd(OFS_STATUS, 32'h55);
        repeat (3) @(posedge hclk);
        give_verdict();
    end
endmodule

// *** src/axis_param_pkg.sv ***
// Constants, layouts and state type of the axis parameter commit bank
package axis_param_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus
    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
    localparam logic [31:0] RDATA_NONE = 32'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Global register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_UNIT = 8'h08;
    localparam logic [7:0] OFS_TASK1 = 8'h0c;
    localparam logic [7:0] OFS_TASK2 = 8'h10;

    // Axis windows: haddr[7:6] selects the axis, haddr[5:2] the word
    localparam logic [1:0] AXIS0_SEL = 2'h1;
    localparam logic [1:0] AXIS1_SEL = 2'h2;
    localparam logic [3:0] IDX_MECH = 4'h0;
    localparam logic [3:0] IDX_SNEG = 4'h1;
    localparam logic [3:0] IDX_SPOS = 4'h2;
    localparam logic [3:0] IDX_WIRE = 4'h3;
    localparam logic [3:0] IDX_REFO = 4'h4;
    localparam logic [3:0] IDX_WORKO = 4'h5;
    localparam logic [3:0] IDX_FEED = 4'h6;
    localparam logic [3:0] IDX_HOME = 4'h7;
    localparam logic [3:0] IDX_JOG = 4'h8;
    localparam logic [3:0] IDX_ACC = 4'h9;
    localparam logic [3:0] IDX_IACC = 4'ha;
    localparam logic [3:0] IDX_WARN = 4'hb;
    localparam logic [3:0] IDX_ABSI = 4'hc;
    localparam logic [3:0] IDX_ABSS = 4'hd;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_RESTART = 0;
    localparam int MECH_UNIT_LSB = 0;
    localparam int MECH_ROT = 2;
    localparam int MECH_STOP = 3;
    localparam int MECH_ABS = 4;
    localparam int MECH_ENCPOL = 5;
    localparam int MECH_HMETH_LSB = 6;
    localparam int MECH_HDIR = 8;
    localparam int MECH_PROX = 9;
    localparam int MECH_WIRE = 10;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 16;
    localparam int ST_PROX_LSB = 0;
    localparam int ST_SLOW_LSB = 2;
    localparam int ST_ALARM_LSB = 4;
    localparam int ST_BOOT = 6;

    ////////////////////////////////////////////////////////////////////////
    // Types and reset values
    typedef struct packed {
        logic [31:0] mech;
        logic [31:0] sneg;
        logic [31:0] spos;
        logic [31:0] wchk;
        logic [31:0] refo;
        logic [31:0] worko;
        logic [31:0] feed;
        logic [31:0] home;
        logic [31:0] jog;
        logic [31:0] acc;
        logic [31:0] iacc;
        logic [31:0] warn;
        logic [31:0] absi;
        logic [31:0] abss;
    } axis_t;

    typedef struct packed {
        axis_t [1:0] stg;
        axis_t [1:0] act;
        logic [31:0] unit_stg;
        logic [31:0] unit_act;
        logic [31:0] task1;
        logic [31:0] task2;
        logic boot;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic [1:0] prox_m;
        logic [1:0] prox_s;
        logic [1:0] stop_m;
        logic [1:0] stop_s;
        logic [1:0] slow;
        logic [1:0] alarm;
        logic [1:0] stop_zero;
        logic [1:0] stop_drain;
        logic [1:0] wire_go;
        logic [1:0] lock_d;
        logic [1:0][15:0] home_spd;
    } state_t;

    localparam state_t STATE_RST = '0;

endpackage

// *** src/axis_parameter_commit_bank.sv ***
// Two-axis parameter store with staged and active copies on AHB-Lite
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module axis_parameter_commit_bank
    import axis_param_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic [1:0] hresp,
    // Commit events from motion logic
    input wire logic [1:0] homing_start,
    input wire logic program_start,
    input wire logic [1:0] operation_start,
    input wire logic manual_mode,
    // Axis status from motion logic
    input wire logic [1:0] homing_active,
    input wire logic [1:0] servo_lock,
    input wire logic [1:0][31:0] accum_error,
    input wire logic [1:0] abs_init_done,
    input wire logic [1:0] abs_srst_done,
    input wire logic [1:0][31:0] abs_value,
    // Axis pins
    input wire logic [1:0] prox_pin,
    input wire logic [1:0] stop_pin,
    // Active unit and task settings
    output logic [31:0] unit_cfg,
    output logic [31:0] task1_range,
    output logic [31:0] task2_range,
    // Active axis settings
    output logic [1:0][1:0] display_unit,
    output logic [1:0] cmd_reverse,
    output logic [1:0] fb_reverse,
    output logic [1:0] absolute_encoder_type,
    output logic [1:0][1:0] home_method,
    output logic [1:0] home_negative,
    output logic [1:0][31:0] stroke_neg,
    output logic [1:0][31:0] stroke_pos,
    output logic [1:0][31:0] wiring_cfg,
    output logic [1:0][31:0] ref_offset,
    output logic [1:0][31:0] work_offset,
    output logic [1:0][31:0] feed_limits,
    output logic [1:0][31:0] jog_limit,
    output logic [1:0][31:0] ramp_times,
    output logic [1:0][31:0] interp_ramp_times,
    // Axis control results
    output logic [1:0][15:0] home_speed,
    output logic [1:0] prox_active,
    output logic [1:0] err_alarm,
    output logic [1:0] stop_zero,
    output logic [1:0] stop_drain,
    output logic [1:0] wiring_check_go
);

    state_t s_r;
    state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Register read view

    function automatic logic [31:0] axis_rd(
        input axis_t sg,
        input axis_t ac,
        input logic [3:0] idx
    );
        logic [31:0] v;

        v = RDATA_NONE;
        case (idx)
            IDX_MECH: v = sg.mech;
            IDX_SNEG: v = sg.sneg;
            IDX_SPOS: v = sg.spos;
            IDX_WIRE: v = sg.wchk;
            IDX_REFO: v = sg.refo;
            IDX_WORKO: v = sg.worko;
            IDX_FEED: v = sg.feed;
            IDX_HOME: v = sg.home;
            IDX_JOG: v = sg.jog;
            IDX_ACC: v = sg.acc;
            IDX_IACC: v = sg.iacc;
            IDX_WARN: v = ac.warn;
            IDX_ABSI: v = ac.absi;
            IDX_ABSS: v = ac.abss;
            default: v = RDATA_NONE;
        endcase

        return v;
    endfunction

    function automatic logic [31:0] status_word(input state_t st);
        logic [31:0] v;
        logic [1:0] pa;

        v = RDATA_NONE;
        pa[0] = st.prox_s[0] ^ st.act[0].mech[MECH_PROX];
        pa[1] = st.prox_s[1] ^ st.act[1].mech[MECH_PROX];
        v[ST_PROX_LSB +: 2] = pa;
        v[ST_SLOW_LSB +: 2] = st.slow;
        v[ST_ALARM_LSB +: 2] = st.alarm;
        v[ST_BOOT] = st.boot;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic ap_valid;
        logic ax;
        logic ax_hit;
        logic restart;
        logic [1:0] pact;
        logic [1:0] ax_sel;

        ap_valid = hsel && htrans[1] && hready;
        ax = 1'b0;
        ax_hit = 1'b0;
        restart = 1'b0;
        pact = 2'h0;
        ax_sel = 2'h0;
        // Hold by default
        s_nxt = s_r;

        // Data phase of a write
        ax_sel = s_r.dp_addr[7:6];
        ax_hit = (ax_sel == AXIS0_SEL) || (ax_sel == AXIS1_SEL);
        ax = (ax_sel == AXIS1_SEL);
        if (s_r.dp_wr)
        begin
            if (ax_hit)
            begin
                case (s_r.dp_addr[5:2])
                    IDX_MECH: s_nxt.stg[ax].mech = hwdata;
                    IDX_SNEG: s_nxt.stg[ax].sneg = hwdata;
                    IDX_SPOS: s_nxt.stg[ax].spos = hwdata;
                    IDX_WIRE: s_nxt.stg[ax].wchk = hwdata;
                    IDX_REFO: s_nxt.stg[ax].refo = hwdata;
                    IDX_WORKO: s_nxt.stg[ax].worko = hwdata;
                    IDX_FEED: s_nxt.stg[ax].feed = hwdata;
                    IDX_HOME: s_nxt.stg[ax].home = hwdata;
                    IDX_JOG: s_nxt.stg[ax].jog = hwdata;
                    IDX_ACC: s_nxt.stg[ax].acc = hwdata;
                    IDX_IACC: s_nxt.stg[ax].iacc = hwdata;
                    IDX_WARN:
                    begin
                        // Servo values act at once
                        s_nxt.stg[ax].warn = hwdata;
                        s_nxt.act[ax].warn = hwdata;
                    end
                    // Encoder results are never written by the bus
                    default: s_nxt.stg[ax].absi = s_r.stg[ax].absi;
                endcase
            end
            else
            begin
                case (s_r.dp_addr)
                    OFS_CTRL: restart = hwdata[CTRL_RESTART];
                    OFS_UNIT: s_nxt.unit_stg = hwdata;
                    OFS_TASK1: s_nxt.task1 = hwdata;
                    OFS_TASK2: s_nxt.task2 = hwdata;
                    default: s_nxt.task1 = s_r.task1;
                endcase
            end
        end

        // Power-up load: first cycle after reset or a unit restart
        s_nxt.boot = 1'b1;
        if (!s_r.boot || restart)
        begin
            s_nxt.unit_act = s_nxt.unit_stg;
        end

        for (int i = 0; i < 2; i++)
        begin
            // Pin synchronisers
            s_nxt.prox_m[i] = prox_pin[i];
            s_nxt.prox_s[i] = s_r.prox_m[i];
            s_nxt.stop_m[i] = stop_pin[i];
            s_nxt.stop_s[i] = s_r.stop_m[i];

            // Power-up
            if (!s_r.boot || restart)
            begin
                s_nxt.act[i].mech = s_nxt.stg[i].mech;
                s_nxt.act[i].sneg = s_nxt.stg[i].sneg;
                s_nxt.act[i].spos = s_nxt.stg[i].spos;
                s_nxt.act[i].wchk = s_nxt.stg[i].wchk;
            end

            // Origin search
            if (homing_start[i])
            begin
                s_nxt.act[i].refo = s_nxt.stg[i].refo;
            end

            // Program start
            if (program_start)
            begin
                s_nxt.act[i].worko = s_nxt.stg[i].worko;
                s_nxt.act[i].iacc = s_nxt.stg[i].iacc;
                if (!manual_mode)
                begin
                    s_nxt.act[i].acc = s_nxt.stg[i].acc;
                end
            end

            // Next operation
            if (operation_start[i])
            begin
                s_nxt.act[i].feed = s_nxt.stg[i].feed;
                s_nxt.act[i].home = s_nxt.stg[i].home;
                s_nxt.act[i].jog = s_nxt.stg[i].jog;
                if (manual_mode)
                begin
                    s_nxt.act[i].acc = s_nxt.stg[i].acc;
                end
            end

            // Encoder results captured when the encoder operation reports done
            if (abs_init_done[i])
            begin
                s_nxt.act[i].absi = abs_value[i];
            end
            if (abs_srst_done[i])
            begin
                s_nxt.act[i].abss = abs_value[i];
            end

            // Homing speed: fast until proximity, then slow
            pact[i] = s_r.prox_s[i] ^ s_r.act[i].mech[MECH_PROX];
            if (!homing_active[i])
            begin
                s_nxt.slow[i] = 1'b0;
            end
            else if (pact[i])
            begin
                s_nxt.slow[i] = 1'b1;
            end
            s_nxt.home_spd[i] = s_nxt.slow[i]
                ? s_r.act[i].home[HI_LSB +: 16]
                : s_r.act[i].home[LO_LSB +: 16];

            // Error counter alarm
            s_nxt.alarm[i] = accum_error[i] > s_r.act[i].warn;

            // Stop handling per configured method
            s_nxt.stop_zero[i] = s_r.stop_s[i]
                && !s_r.act[i].mech[MECH_STOP];
            s_nxt.stop_drain[i] = s_r.stop_s[i]
                && s_r.act[i].mech[MECH_STOP];

            // Wiring check on the rising edge of servo lock
            s_nxt.lock_d[i] = servo_lock[i];
            s_nxt.wire_go[i] = servo_lock[i] && !s_r.lock_d[i]
                && s_r.act[i].mech[MECH_WIRE];
        end

        // Address phase: latch writes, answer reads next cycle
        s_nxt.dp_wr = ap_valid && hwrite;
        s_nxt.dp_addr = haddr[7:0];
        if (ap_valid && !hwrite)
        begin
            ax_sel = haddr[7:6];
            ax = (ax_sel == AXIS1_SEL);
            if ((ax_sel == AXIS0_SEL) || (ax_sel == AXIS1_SEL))
            begin
                s_nxt.rdata = axis_rd(s_nxt.stg[ax], s_nxt.act[ax],
                    haddr[5:2]);
            end
            else
            begin
                case (haddr[7:0])
                    OFS_STATUS: s_nxt.rdata = status_word(s_r);
                    OFS_UNIT: s_nxt.rdata = s_nxt.unit_stg;
                    OFS_TASK1: s_nxt.rdata = s_nxt.task1;
                    OFS_TASK2: s_nxt.rdata = s_nxt.task2;
                    default: s_nxt.rdata = RDATA_NONE;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r <= STATE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Bus answer
    assign hreadyout = 1'b1;
    assign hresp = RESP_OKAY;
    assign hrdata = s_r.rdata;

    // Active values
    assign unit_cfg = s_r.unit_act;
    assign task1_range = s_r.task1;
    assign task2_range = s_r.task2;
    assign home_speed = s_r.home_spd;
    assign err_alarm = s_r.alarm;
    assign stop_zero = s_r.stop_zero;
    assign stop_drain = s_r.stop_drain;
    assign wiring_check_go = s_r.wire_go;

    for (genvar g = 0; g < 2; g++)
    begin : g_axis
        assign display_unit[g] =
            s_r.act[g].mech[MECH_UNIT_LSB +: 2];
        assign cmd_reverse[g] = s_r.act[g].mech[MECH_ROT];
        assign fb_reverse[g] = s_r.act[g].mech[MECH_ENCPOL];
        assign absolute_encoder_type[g] =
            s_r.act[g].mech[MECH_ABS];
        assign home_method[g] =
            s_r.act[g].mech[MECH_HMETH_LSB +: 2];
        assign home_negative[g] = s_r.act[g].mech[MECH_HDIR];
        assign prox_active[g] =
            s_r.prox_s[g] ^ s_r.act[g].mech[MECH_PROX];
        assign stroke_neg[g] = s_r.act[g].sneg;
        assign stroke_pos[g] = s_r.act[g].spos;
        assign wiring_cfg[g] = s_r.act[g].wchk;
        assign ref_offset[g] = s_r.act[g].refo;
        assign work_offset[g] = s_r.act[g].worko;
        assign feed_limits[g] = s_r.act[g].feed;
        assign jog_limit[g] = s_r.act[g].jog;
        assign ramp_times[g] = s_r.act[g].acc;
        assign interp_ramp_times[g] = s_r.act[g].iacc;
    end

endmodule
